// ---- core/mfp_pkg.sv ----
/*
  Shared constants and types for the multi-function pin port: register
  offsets, pin function codes, bit positions, timing and carrier structs.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package mfp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFF     = 8'h00; // interrupt source enables
  localparam logic [7:0]  PIN_CFG_OFF  = 8'h04; // pin function fields [5:0]
  localparam logic [7:0]  PIN_IN_OFF   = 8'h08; // sampled pin levels
  localparam logic [7:0]  IRQ_STAT_OFF = 8'h0c; // sticky events, w1c
  localparam logic [7:0]  IRQ_MASK_OFF = 8'h10; // interrupt mask
  localparam logic [7:0]  MODE_OFF     = 8'h14; // interface mode, stereo

  // reset values
  localparam logic [5:0]  PIN_CFG_RST  = 6'h00;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  //////////////////////////////////////////////////////////////////////////
  // two-bit pin function codes
  localparam logic [1:0]  FN_HIZ       = 2'h0; // input, not driven
  localparam logic [1:0]  FN_SPECIAL   = 2'h1; // irq or stereo indicator
  localparam logic [1:0]  FN_LOW       = 2'h2; // drive low
  localparam logic [1:0]  FN_HIGH      = 2'h3; // drive high

  // control and status bit positions
  localparam int          CTRL_DS_BIT  = 0; // data service irq enable
  localparam int          CTRL_STC_BIT = 1; // seek/tune complete irq enable
  localparam int          EVT_STC_BIT  = 0;
  localparam int          EVT_DS_BIT   = 1;

  // {third pin, first pin} levels at reset release that pick 3-wire
  localparam logic [1:0]  MODE_3WIRE_CODE = 2'h2;

  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // timing: least low time of the irq pin pulse, rounded up
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          PULSE_MIN_MS  = 5;
  localparam int          PULSE_CYCLES  =
    (PULSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PULSE_CNT_W   = 21;

  //////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [1:0] pin3;   // indicator capable pin
    logic [1:0] pin2;   // irq capable pin
    logic [1:0] pin1;   // multi pin one
  } pin_cfg_t;

  typedef struct packed {
    logic stereo;       // level: receiver in stereo
    logic group_valid;  // pulse: valid data service group received
    logic tune_done;    // level: seek_tune_complete
  } rx_event_t;

  typedef enum logic {CAP_ARMED, CAP_DONE} cap_state_t;

endpackage

// ---- core/pin_sync.sv ----
/*
  Two-flop synchroniser for the asynchronous pin inputs, one stage pair
  per bit. Assumes the pins are stable for at least a few clock periods.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage; no reset so the
  // pin level seen during reset passes straight through
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_in) begin
        meta_reg[i] <= d_in[i];
        q_out[i]    <= meta_reg[i];
      end
    end
  endgenerate

endmodule // pin_sync

// ---- core/multi_function_pin_port.sv ----
/*
  Multi-function pin port: three general purpose pins, one of them an
  interrupt request output, one a stereo indicator, plus strap capture
  of the control interface mode at reset release. Registers over
  AXI4-Lite. Assumes receiver events arrive on mclk_in and that the pad
  ring resolves each pin from out/oe_n and applies the pull-down.
*/
//
// Behaviour
// - pins one and three strap interface mode
// - after powerup all three pins are gpio
// - pin two may signal tune or data irq
// - pin three may show stereo or mono
// - function fields sit in config bits 5:0
// - pin three pull-down only during reset
// - gpio works regardless of supplies or enables
// - data group irq pulses pin two low 5ms
// - early tune irq fires on default tune
`timescale 1ns/1ps
module multi_function_pin_port #(
  parameter int unsigned PULSE_CYCLES = mfp_pkg::PULSE_CYCLES
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr_in,
  input  wire logic                    s_axi_awvalid_in,
  output logic                         s_axi_awready_out,
  input  wire logic [31:0]             s_axi_wdata_in,
  input  wire logic [3:0]              s_axi_wstrb_in,
  input  wire logic                    s_axi_wvalid_in,
  output logic                         s_axi_wready_out,
  output logic [1:0]                   s_axi_bresp_out,
  output logic                         s_axi_bvalid_out,
  input  wire logic                    s_axi_bready_in,
  input  wire logic [7:0]              s_axi_araddr_in,
  input  wire logic                    s_axi_arvalid_in,
  output logic                         s_axi_arready_out,
  output logic [31:0]                  s_axi_rdata_out,
  output logic [1:0]                   s_axi_rresp_out,
  output logic                         s_axi_rvalid_out,
  input  wire logic                    s_axi_rready_in,
  // receiver status, same clock
  input  wire mfp_pkg::rx_event_t      rx_event_in,
  // pins, split into in / out / enable
  input  wire logic [2:0]              pin_in_in,
  output logic      [2:0]              pin_out_out,
  output logic      [2:0]              pin_oe_n_out,
  output logic                         pulldown_en_out,
  output logic                         iface_mode_3wire_out,
  output logic                         irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by the read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == mfp_pkg::CTRL_OFF)     ||
                (a == mfp_pkg::PIN_CFG_OFF)  ||
                (a == mfp_pkg::PIN_IN_OFF)   ||
                (a == mfp_pkg::IRQ_STAT_OFF) ||
                (a == mfp_pkg::IRQ_MASK_OFF) ||
                (a == mfp_pkg::MODE_OFF);
  endfunction

  // {oe_n, out} for one pin from its function code
  function automatic logic [1:0] pin_drive(input logic [1:0] fn,
                                           input logic       has_spec,
                                           input logic       spec_lvl);
    case (fn)
      mfp_pkg::FN_LOW:     pin_drive = 2'h0;
      mfp_pkg::FN_HIGH:    pin_drive = 2'h1;
      mfp_pkg::FN_SPECIAL: pin_drive = has_spec ? {1'b0, spec_lvl} : 2'h2;
      default:             pin_drive = 2'h2; // released, input
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [2:0]                        pin_level;     // synchronised pins
  logic [2:0]                        pin_in_reg;    // software view
  mfp_pkg::pin_cfg_t                 cfg_reg;       // function fields
  logic [1:0]                        ctrl_reg;      // irq source enables
  logic [1:0]                        irq_stat_reg;  // sticky events
  logic [1:0]                        irq_mask_reg;  // 1 = enabled
  mfp_pkg::cap_state_t               cap_reg;       // strap capture
  logic                              stc_prev_reg;  // edge detect
  logic [mfp_pkg::PULSE_CNT_W-1:0]   pulse_cnt_reg; // irq pin low time
  logic [7:0]                        aw_addr_reg;
  logic [31:0]                       w_data_reg;
  logic                              w_strb0_reg;
  logic                              do_write;
  logic                              stc_rise;
  logic                              pulse_trig;
  logic                              pulse_active;
  logic [1:0]                        evt_set;
  logic [1:0]                        evt_clr;
  logic [5:0]                        drv_next;      // {oe_n,out} x3
  logic [31:0]                       rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  pin_sync #(
    .W (3)
  ) u_pin_sync (
    .mclk_in (mclk_in),
    .d_in    (pin_in_in),
    .q_out   (pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pull-down on the third pin only while reset is held
  always_ff @(posedge mclk_in) begin
    pulldown_en_out <= !rst_n_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: the first edge after release takes the levels the
  // host held through reset; nothing but a new reset re-arms it
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cap_reg              <= mfp_pkg::CAP_ARMED;
      iface_mode_3wire_out <= 1'b0;
    end else begin
      case (cap_reg)
        mfp_pkg::CAP_ARMED: begin
          iface_mode_3wire_out <= ({pin_level[2], pin_level[0]} ==
                                   mfp_pkg::MODE_3WIRE_CODE);
          cap_reg              <= mfp_pkg::CAP_DONE;
        end
        mfp_pkg::CAP_DONE: begin
          cap_reg <= mfp_pkg::CAP_DONE;
        end
        default: begin
          cap_reg <= mfp_pkg::CAP_DONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, the write
  // lands once both are held and no response is pending
  assign do_write = !s_axi_awready_out && !s_axi_wready_out &&
                    !s_axi_bvalid_out;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      aw_addr_reg       <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      aw_addr_reg       <= s_axi_awaddr_in;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_wready_out <= 1'b1;
      w_data_reg       <= 32'h0000_0000;
      w_strb0_reg      <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      w_data_reg       <= s_axi_wdata_in;
      w_strb0_reg      <= s_axi_wstrb_in[0]; // all fields in lane 0
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  // response raised on the same edge the write lands
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= mfp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= is_mapped(aw_addr_reg) ? mfp_pkg::RESP_OKAY :
                                                   mfp_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; gpio settings are never gated by power state
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_reg      <= mfp_pkg::PIN_CFG_RST;
      ctrl_reg     <= mfp_pkg::CTRL_RST;
      irq_mask_reg <= mfp_pkg::MASK_RST;
    end else if (do_write && w_strb0_reg) begin
      case (aw_addr_reg)
        mfp_pkg::PIN_CFG_OFF:  cfg_reg      <= w_data_reg[5:0];
        mfp_pkg::CTRL_OFF:     ctrl_reg     <= w_data_reg[1:0];
        mfp_pkg::IRQ_MASK_OFF: irq_mask_reg <= w_data_reg[1:0];
        default: begin
          cfg_reg <= cfg_reg; // status, read-only or unmapped
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: rising edge of tune complete, each valid data group
  assign stc_rise = rx_event_in.tune_done && !stc_prev_reg;
  assign evt_set  = {rx_event_in.group_valid, stc_rise};
  assign evt_clr  = (do_write && w_strb0_reg &&
                     aw_addr_reg == mfp_pkg::IRQ_STAT_OFF) ?
                    w_data_reg[1:0] : 2'h0;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stc_prev_reg <= 1'b0;
    end else begin
      stc_prev_reg <= rx_event_in.tune_done;
    end
  end

  // sticky status; a set in the clearing cycle survives
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // irq pin pulse; no powerup gate, so an enable set early also
  // reports the default tune done during powerup
  assign pulse_trig = (cfg_reg.pin2 == mfp_pkg::FN_SPECIAL) &&
    ((ctrl_reg[mfp_pkg::CTRL_DS_BIT] && rx_event_in.group_valid) ||
     (ctrl_reg[mfp_pkg::CTRL_STC_BIT] && stc_rise));
  assign pulse_active = (pulse_cnt_reg != '0);

  // a new event restarts the full low time
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pulse_cnt_reg <= '0;
    end else if (pulse_trig) begin
      pulse_cnt_reg <= mfp_pkg::PULSE_CNT_W'(PULSE_CYCLES);
    end else if (pulse_active) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: pin two idles high and pulses low, pin three follows
  // stereo, pin one has no special function and stays released
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      assign drv_next[2*g +: 2] = pin_drive(
        cfg_reg[2*g +: 2],
        (g != 0),
        (g == 1) ? !pulse_active : rx_event_in.stereo);
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_oe_n_out <= 3'h7;
      pin_out_out  <= 3'h0;
    end else begin
      pin_oe_n_out <= {drv_next[5], drv_next[3], drv_next[1]};
      pin_out_out  <= {drv_next[4], drv_next[2], drv_next[0]};
    end
  end

  // sampled levels for software, whatever the pin function
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_in_reg <= 3'h0;
    end else begin
      pin_in_reg <= pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one outstanding read, data one cycle after address
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr_in)
      mfp_pkg::CTRL_OFF:     rd_mux[1:0] = ctrl_reg;
      mfp_pkg::PIN_CFG_OFF:  rd_mux[5:0] = cfg_reg;
      mfp_pkg::PIN_IN_OFF:   rd_mux[2:0] = pin_in_reg;
      mfp_pkg::IRQ_STAT_OFF: rd_mux[1:0] = irq_stat_reg;
      mfp_pkg::IRQ_MASK_OFF: rd_mux[1:0] = irq_mask_reg;
      mfp_pkg::MODE_OFF:     rd_mux[1:0] = {rx_event_in.stereo,
                                            iface_mode_3wire_out};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= mfp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_mux;
      s_axi_rresp_out   <= is_mapped(s_axi_araddr_in) ?
                           mfp_pkg::RESP_OKAY : mfp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_ds_trigger;
    cfg_reg.pin2 == mfp_pkg::FN_SPECIAL &&
    ctrl_reg[mfp_pkg::CTRL_DS_BIT] && rx_event_in.group_valid;
  endsequence

  sequence seq_irq_pin_low;
    !pin_oe_n_out[1] && !pin_out_out[1];
  endsequence

  AST_PULLDOWN_RESET: assert property (disable iff (1'b0)
    1'b1 |=> pulldown_en_out == !$past(rst_n_in))
    else $error("pull-down wrong for reset level");

  AST_MODE_CAPTURE: assert property (
    rst_n_in && cap_reg == mfp_pkg::CAP_ARMED |=> iface_mode_3wire_out ==
      ({$past(pin_level[2]), $past(pin_level[0])} ==
       mfp_pkg::MODE_3WIRE_CODE))
    else $error("interface mode not taken from strap pins");

  AST_MODE_HELD: assert property (
    cap_reg == mfp_pkg::CAP_DONE |=> $stable(iface_mode_3wire_out))
    else $error("interface mode changed after capture");

  AST_IRQ_PIN_PULSE: assert property (
    seq_ds_trigger ##1 cfg_reg.pin2 == mfp_pkg::FN_SPECIAL
      |-> ##1 seq_irq_pin_low)
    else $error("irq pin not driven low after data group");

  AST_PULSE_HOLD: assert property (
    pulse_cnt_reg > 1 |=> pulse_active)
    else $error("irq pin pulse ended early");

  AST_STEREO_PIN: assert property (
    cfg_reg.pin3 == mfp_pkg::FN_SPECIAL |=>
      !pin_oe_n_out[2] && pin_out_out[2] == $past(rx_event_in.stereo))
    else $error("indicator pin does not follow stereo");

  AST_GPIO_DRIVE: assert property (
    cfg_reg.pin1 == mfp_pkg::FN_HIGH |=> !pin_oe_n_out[0] && pin_out_out[0])
    else $error("pin one not driven high");

  AST_GPIO_INPUT: assert property (
    cfg_reg.pin2 == mfp_pkg::FN_HIZ |=> pin_oe_n_out[1] ##1
      pin_in_reg[1] == $past(pin_level[1]))
    else $error("released pin not sampled for software");

  AST_IRQ_LEVEL: assert property (
    |(irq_stat_reg & irq_mask_reg) |=> irq_out)
    else $error("interrupt output missing");

endmodule // multi_function_pin_port

// ---- bench/pin_host_model.sv ----
/*
  Host side of the pin port: resolves the three pin wires from the
  port's drive, the host's drive and the weak pull-down.
  Assumes one clock and that the host never fights a driven pin.
*/
`timescale 1ns/1ps
module pin_host_model (
  input  wire logic       mclk_in,
  input  wire logic       pulldown_en_in,
  input  wire logic [2:0] pin_out_in,
  input  wire logic [2:0] pin_oe_n_in,
  input  wire logic [2:0] host_drv_in,  // host drives the pin when high
  input  wire logic [2:0] host_lvl_in,  // level the host drives
  output logic      [2:0] pin_lvl_out
);
  logic [2:0] float_q = 3'h5;  // level of a wire nobody drives

  //////////////////////////////////////////////////////////////////////
  // floating wires wander every cycle so a stale level cannot pass
  always @(posedge mclk_in) begin
    float_q <= ~float_q;
  end

  // wire level per pin, port first, then host, then pull-down
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe_n_in[i] == 1'b0) pin_lvl_out[i] = pin_out_in[i];
      else if (host_drv_in[i]) pin_lvl_out[i] = host_lvl_in[i];
      else if (i == 2 && pulldown_en_in) pin_lvl_out[i] = 1'b0;
      else pin_lvl_out[i] = float_q[i];
    end
  end
endmodule // pin_host_model

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the multi-function pin port: AXI4-Lite tasks,
  strap capture, gpio, stereo indicator and the irq pin pulse.
  Assumes the design holds its own assertions and a shortened pulse.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int PULSE = 20;  // short pulse keeps the run brief

  logic                mclk_in  = 1'b0;
  logic                rst_n_in = 1'b0;
  logic [7:0]          aw_addr  = 8'h00;
  logic                aw_valid = 1'b0;
  logic [31:0]         w_data   = 32'h0;
  logic [3:0]          w_strb   = 4'hf;  // full word writes only
  logic                w_valid  = 1'b0;
  logic                b_ready  = 1'b0;
  logic [7:0]          ar_addr  = 8'h00;
  logic                ar_valid = 1'b0;
  logic                r_ready  = 1'b0;
  mfp_pkg::rx_event_t  rx_ev    = '0;    // receiver status stimulus
  logic [2:0]          host_drv = 3'h0;
  logic [2:0]          host_lvl = 3'h0;
  logic                aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0]          b_resp, r_resp;
  logic [31:0]         r_data;
  logic [2:0]          pin_lvl, pin_out, oe_n;
  logic                pd_en, mode3, irq;
  int                  err_total, samples_checked, n;

  always #2 mclk_in = ~mclk_in;

  multi_function_pin_port #(.PULSE_CYCLES(PULSE)) dut_u (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
    .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
    .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
    .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
    .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
    .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
    .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
    .s_axi_rready_in(r_ready), .rx_event_in(rx_ev), .pin_in_in(pin_lvl),
    .pin_out_out(pin_out), .pin_oe_n_out(oe_n), .pulldown_en_out(pd_en),
    .iface_mode_3wire_out(mode3), .irq_out(irq));

  pin_host_model host_u (
    .mclk_in(mclk_in), .pulldown_en_in(pd_en), .pin_out_in(pin_out),
    .pin_oe_n_in(oe_n), .host_drv_in(host_drv), .host_lvl_in(host_lvl),
    .pin_lvl_out(pin_lvl));

  //////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // write: address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw_left, w_left;
    aw_left = 1;
    w_left = 1;
    @(posedge mclk_in);
    aw_addr <= a;
    aw_valid <= 1'b1;
    w_data <= d;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge mclk_in);
      if (aw_left && aw_ready === 1'b1) begin
        aw_valid <= 1'b0;
        aw_left = 0;
      end
      if (w_left && w_ready === 1'b1) begin
        w_valid <= 1'b0;
        w_left = 0;
      end
    end
    while (b_valid !== 1'b1) @(posedge mclk_in);
    b_ready <= 1'b0;
    chk("bresp", {30'h0, b_resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge mclk_in);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(posedge mclk_in); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    while (r_valid !== 1'b1) @(posedge mclk_in);
    r_ready <= 1'b0;
    chk("rdata", r_data, e);
    chk("rresp", {30'h0, r_resp}, {30'h0, er});
  endtask

  // reset with straps {pin three, pin one}, then move the straps
  task automatic rst_seq(input logic [1:0] strap);
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    host_drv <= 3'b101;
    host_lvl <= {strap[1], 1'b0, strap[0]};
    repeat (3) @(posedge mclk_in);
    #1;
    chk("pulldown", pd_en, 1'b1);
    chk("oe_n", oe_n, 3'b111);
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk("pulldown", pd_en, 1'b0);
    chk("mode", mode3, strap == mfp_pkg::MODE_3WIRE_CODE);
    @(posedge mclk_in);
    host_lvl <= ~host_lvl;
    repeat (6) @(posedge mclk_in);
    #1;
    chk("mode", mode3, strap == mfp_pkg::MODE_3WIRE_CODE);
    host_drv <= 3'h0;
  endtask

  // one event, then count the cycles the irq pin stays low
  task automatic fire(input bit tune, output int len);
    @(posedge mclk_in);
    if (tune) rx_ev.tune_done <= 1'b1;
    else rx_ev.group_valid <= 1'b1;
    @(posedge mclk_in);
    rx_ev.group_valid <= 1'b0;
    #1;
    len = 0;
    for (int i = 0; i < 10 && pin_out[1] !== 1'b0; i++) @(posedge mclk_in) #1;
    while (pin_out[1] === 1'b0 && oe_n[1] === 1'b0 && len < 1000) begin
      @(posedge mclk_in);
      #1;
      len++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [5:0] cfg [3] = '{6'h2a, 6'h3f, 6'h3b};  // low, high, mixed
    logic [2:0] lvl [3] = '{3'h0, 3'h7, 3'h5};
    rst_seq(2'b10);
    // early tune irq, before any settling time
    wr(mfp_pkg::CTRL_OFF, 32'h2, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::IRQ_MASK_OFF, 32'h1, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::PIN_CFG_OFF, 32'h04, mfp_pkg::RESP_OKAY);
    #1 chk("pin2 idle", {oe_n[1], pin_out[1]}, 2'b01);
    fire(1'b1, n);
    chk("tune pulse", n, PULSE);
    chk("irq", irq, 1'b1);
    rd(mfp_pkg::IRQ_STAT_OFF, 32'h1, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::IRQ_STAT_OFF, 32'h1, mfp_pkg::RESP_OKAY);
    @(posedge mclk_in) #1 chk("irq", irq, 1'b0);
    wr(mfp_pkg::CTRL_OFF, 32'h1, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::IRQ_MASK_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    fire(1'b0, n);
    chk("group pulse", n, PULSE);
    chk("masked irq", irq, 1'b0);
    rd(mfp_pkg::IRQ_STAT_OFF, 32'h2, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::IRQ_STAT_OFF, 32'h2, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::CTRL_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    fire(1'b0, n);
    chk("no pulse", n, 0);
    $display("test irq done");
    // register map, field width and unmapped place
    rst_seq(2'b10);
    rd(mfp_pkg::CTRL_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    rd(mfp_pkg::PIN_CFG_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    rd(mfp_pkg::IRQ_MASK_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    rd(mfp_pkg::MODE_OFF, 32'h1, mfp_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, mfp_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, mfp_pkg::RESP_SLVERR);
    wr(mfp_pkg::PIN_CFG_OFF, 32'hffffffff, mfp_pkg::RESP_OKAY);
    rd(mfp_pkg::PIN_CFG_OFF, 32'h3f, mfp_pkg::RESP_OKAY);
    $display("test registers done");
    // gpio outputs from a table, then inputs with enables off, then on
    for (int i = 0; i < 3; i++) begin
      wr(mfp_pkg::PIN_CFG_OFF, {26'h0, cfg[i]}, mfp_pkg::RESP_OKAY);
      #1 chk("oe_n", oe_n, 3'h0);
      chk("pin_out", pin_out, lvl[i]);
    end
    wr(mfp_pkg::PIN_CFG_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    #1 chk("oe_n", oe_n, 3'h7);
    host_drv <= 3'h7;
    host_lvl <= 3'h6;
    repeat (4) @(posedge mclk_in);
    rd(mfp_pkg::PIN_IN_OFF, 32'h6, mfp_pkg::RESP_OKAY);
    wr(mfp_pkg::CTRL_OFF, 32'h3, mfp_pkg::RESP_OKAY);
    host_lvl <= 3'h3;
    repeat (4) @(posedge mclk_in);
    rd(mfp_pkg::PIN_IN_OFF, 32'h3, mfp_pkg::RESP_OKAY);
    host_drv <= 3'h0;
    $display("test gpio done");
    // stereo indicator on pin three
    wr(mfp_pkg::PIN_CFG_OFF, 32'h10, mfp_pkg::RESP_OKAY);
    rx_ev.stereo <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 chk("stereo", {oe_n[2], pin_out[2]}, 2'b01);
    rd(mfp_pkg::MODE_OFF, 32'h3, mfp_pkg::RESP_OKAY);
    rx_ev.stereo <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk("mono", {oe_n[2], pin_out[2]}, 2'b00);
    $display("test stereo done");
    rst_seq(2'b00);
    rd(mfp_pkg::MODE_OFF, 32'h0, mfp_pkg::RESP_OKAY);
    $display("test second reset done");
    print_verdict();
  end

  // watchdog: the tests need a few thousand cycles at most
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule // tb_top
